// ===== core/shreg_regs.svh
// constants for the parallel-load shift register
`ifndef SHREG_REGS_SVH
`define SHREG_REGS_SVH

`define SHREG_STAGES 8
`define SHREG_STAGE_BIT_RESET 1'b0
`define SHREG_INV_RESET 1'b1
`define SHREG_FILTER_BIT_RESET 1'b0
`define SHREG_EDGE_RESET 1'b0

`endif

// ===== core/shreg_pkg.sv
// types for the parallel-load shift register
package shreg_pkg;

  typedef struct packed {
    logic shift_load_select;
    logic clock_in;
    logic clock_block_input;
    logic serial_data_in;
  } pin_ctrl_t;

  typedef enum logic {
    MODE_LOAD = 1'b0,
    MODE_SHIFT = 1'b1
  } mode_t;

endpackage

// ===== core/pin_filter.sv
// three-flop input synchroniser with agreement filter
`timescale 1ns/1ns
`include "shreg_regs.svh"

module pin_filter #(
  parameter int WIDTH = 12
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);

  logic [WIDTH-1:0] sync1;
  logic [WIDTH-1:0] sync2;
  logic [WIDTH-1:0] sync3;
  logic [WIDTH-1:0] next_pin_out;

  // -------------------------------------------------------------------------
  // per-bit agreement: a bit moves only when stages two and three agree
  // -------------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign next_pin_out[i] = (sync2[i] == sync3[i]) ? sync3[i] : pin_out[i];
    end
  endgenerate

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1 <= {WIDTH{`SHREG_FILTER_BIT_RESET}};
      sync2 <= {WIDTH{`SHREG_FILTER_BIT_RESET}};
      sync3 <= {WIDTH{`SHREG_FILTER_BIT_RESET}};
      pin_out <= {WIDTH{`SHREG_FILTER_BIT_RESET}};
    end else begin
      sync1 <= pin_in;
      sync2 <= sync1;
      sync3 <= sync2;
      pin_out <= next_pin_out;
    end
  end

endmodule

// ===== core/parallel_load_shift_register8.sv
// eight-stage parallel-load, serial-out shift register core
//
// Behaviour
// - eight stages; while select is low each stage takes its own parallel input
// - load follows select level alone, regardless of clock, inhibit and serial input
// - while select is high parallel inputs are ignored; contents hold unless shifting
// - shift on clock rise with select high, inhibit low; high clock or inhibit holds
// - clock and inhibit are symmetric; inhibit rise with clock low also shifts
// - each shift moves every stage one place toward the last stage
// - each shift captures the serial input into the first stage
// - serial output follows last stage; inverted output is always its complement
// - two modes, load and shift, picked only by the select level
// - reset forces every stage to a defined state before normal operation
`timescale 1ns/1ns
`include "shreg_regs.svh"

module parallel_load_shift_register8 #(
  parameter int STAGES = `SHREG_STAGES
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [STAGES-1:0] parallel_data_in,
  input wire logic shift_load_select,
  input wire logic clock_in,
  input wire logic clock_block_input,
  input wire logic serial_data_in,
  output logic serial_out_true,
  output logic serial_out_inverted
);

  localparam int CTRL_BITS = $bits(shreg_pkg::pin_ctrl_t);
  localparam int FILT_BITS = CTRL_BITS + STAGES;

  // -------------------------------------------------------------------------
  // input conditioning
  // -------------------------------------------------------------------------
  shreg_pkg::pin_ctrl_t ctrl_raw;
  shreg_pkg::pin_ctrl_t ctrl_f;
  logic [STAGES-1:0] par_f;
  logic [FILT_BITS-1:0] filt_in;
  logic [FILT_BITS-1:0] filt_out;

  assign ctrl_raw.shift_load_select = shift_load_select;
  assign ctrl_raw.clock_in = clock_in;
  assign ctrl_raw.clock_block_input = clock_block_input;
  assign ctrl_raw.serial_data_in = serial_data_in;
  assign filt_in = {parallel_data_in, ctrl_raw};

  // one shared filter gives every pin the same latency, so data stays aligned to its clocks
  pin_filter #(
    .WIDTH(FILT_BITS)
  ) u_pin_filter (
    .ref_clk(ref_clk),
    .rst(rst),
    .pin_in(filt_in),
    .pin_out(filt_out)
  );

  assign ctrl_f = shreg_pkg::pin_ctrl_t'(filt_out[CTRL_BITS-1:0]);
  assign par_f = filt_out[FILT_BITS-1:CTRL_BITS];

  // -------------------------------------------------------------------------
  // clocking detection
  // -------------------------------------------------------------------------
  // the stage clock is the or of clock and inhibit: it rises when one input
  // rises while the other is low, and stays high while either one is high
  logic gated_clk;
  logic gated_clk_prev;
  // per-pin history, kept apart from the or so the checks can tell which input rose
  logic clk_prev;
  logic inh_prev;
  logic shift_event;
  shreg_pkg::mode_t mode;

  assign gated_clk = ctrl_f.clock_in | ctrl_f.clock_block_input;
  assign mode = ctrl_f.shift_load_select ? shreg_pkg::MODE_SHIFT
                                         : shreg_pkg::MODE_LOAD;
  assign shift_event = (mode == shreg_pkg::MODE_SHIFT) && gated_clk
                       && !gated_clk_prev;

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gated_clk_prev <= `SHREG_EDGE_RESET;
      clk_prev <= `SHREG_EDGE_RESET;
      inh_prev <= `SHREG_EDGE_RESET;
    end else begin
      gated_clk_prev <= gated_clk;
      clk_prev <= ctrl_f.clock_in;
      inh_prev <= ctrl_f.clock_block_input;
    end
  end

  // -------------------------------------------------------------------------
  // stage register
  // -------------------------------------------------------------------------
  logic [STAGES-1:0] stage;
  logic [STAGES-1:0] next_stage;
  logic [STAGES-1:0] shifted;

  // bit 0 is the first stage, fed by the serial input; the top bit is the last
  assign shifted = {stage[STAGES-2:0], ctrl_f.serial_data_in};

  always_comb begin
    next_stage = stage;
    unique case (mode)
      shreg_pkg::MODE_LOAD: begin
        next_stage = par_f;
      end
      shreg_pkg::MODE_SHIFT: begin
        next_stage = shift_event ? shifted : stage;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      stage <= {STAGES{`SHREG_STAGE_BIT_RESET}};
      serial_out_true <= `SHREG_STAGE_BIT_RESET;
      serial_out_inverted <= `SHREG_INV_RESET;
    end else begin
      stage <= next_stage;
      serial_out_true <= next_stage[STAGES-1];
      serial_out_inverted <= ~next_stage[STAGES-1];
    end
  end

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  property p_load_follows;
    @(posedge ref_clk) disable iff (rst)
      !ctrl_f.shift_load_select |=> stage == $past(par_f);
  endproperty
  a_load_follows: assert property (p_load_follows)
    else $error("stages did not follow parallel inputs in load mode");

  property p_load_ignores_clocks;
    @(posedge ref_clk) disable iff (rst)
      (!ctrl_f.shift_load_select && gated_clk && !gated_clk_prev)
      |=> stage == $past(par_f);
  endproperty
  a_load_ignores_clocks: assert property (p_load_ignores_clocks)
    else $error("clock edge disturbed a parallel load");

  property p_hold_without_edge;
    @(posedge ref_clk) disable iff (rst)
      (ctrl_f.shift_load_select && !(gated_clk && !gated_clk_prev))
      |=> $stable(stage);
  endproperty
  a_hold_without_edge: assert property (p_hold_without_edge)
    else $error("stages changed in shift mode without a clock edge");

  property p_inhibit_high_holds;
    @(posedge ref_clk) disable iff (rst)
      (ctrl_f.shift_load_select && ctrl_f.clock_block_input && inh_prev)
      |=> $stable(stage);
  endproperty
  a_inhibit_high_holds: assert property (p_inhibit_high_holds)
    else $error("stages shifted while clock inhibit was held high");

  property p_clock_high_holds;
    @(posedge ref_clk) disable iff (rst)
      (ctrl_f.shift_load_select && ctrl_f.clock_in && clk_prev)
      |=> $stable(stage);
  endproperty
  a_clock_high_holds: assert property (p_clock_high_holds)
    else $error("stages shifted while clock was held high");

  property p_clock_rise_shifts;
    @(posedge ref_clk) disable iff (rst)
      (ctrl_f.shift_load_select && ctrl_f.clock_in && !clk_prev
       && !ctrl_f.clock_block_input && !inh_prev)
      |=> stage == {$past(stage[STAGES-2:0]), $past(ctrl_f.serial_data_in)};
  endproperty
  a_clock_rise_shifts: assert property (p_clock_rise_shifts)
    else $error("clock rise did not shift the stages");

  property p_inhibit_rise_shifts;
    @(posedge ref_clk) disable iff (rst)
      (ctrl_f.shift_load_select && ctrl_f.clock_block_input && !inh_prev
       && !ctrl_f.clock_in && !clk_prev)
      |=> stage == {$past(stage[STAGES-2:0]), $past(ctrl_f.serial_data_in)};
  endproperty
  a_inhibit_rise_shifts: assert property (p_inhibit_rise_shifts)
    else $error("inhibit rise with clock low did not shift");

  property p_serial_capture;
    @(posedge ref_clk) disable iff (rst)
      shift_event |=> stage[0] == $past(ctrl_f.serial_data_in)
                      && serial_out_true == $past(stage[STAGES-2]);
  endproperty
  a_serial_capture: assert property (p_serial_capture)
    else $error("serial input not captured into the first stage");

  property p_outputs_track;
    @(posedge ref_clk) disable iff (rst)
      serial_out_true == stage[STAGES-1] && serial_out_inverted == !serial_out_true;
  endproperty
  a_outputs_track: assert property (p_outputs_track)
    else $error("serial outputs do not match the last stage");

  // stages may only move in load mode or on a clocking edge in shift mode
  property p_mode_by_select;
    @(posedge ref_clk) disable iff (rst)
      !$stable(stage) |-> $past(mode) == shreg_pkg::MODE_LOAD
                          || ($past(gated_clk) && !$past(gated_clk_prev));
  endproperty
  a_mode_by_select: assert property (p_mode_by_select)
    else $error("mode does not follow the select level");

  property p_reset_clears;
    @(posedge ref_clk)
      rst |-> stage == {STAGES{`SHREG_STAGE_BIT_RESET}} && !serial_out_true
              && serial_out_inverted;
  endproperty
  a_reset_clears: assert property (p_reset_clears)
    else $error("reset did not clear the stages");

endmodule

// ===== tb/shreg_ctrl_model.sv
// controller model that drives the shift register pins
`timescale 1ns/1ns
module shreg_ctrl_model (
  input wire logic ref_clk,
  output logic [7:0] par,
  output shreg_pkg::pin_ctrl_t ctl
);
  initial begin
    par = 8'h00;
    ctl = '0;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // load with a stray clock pulse, then leave load and disturb the inputs
  task automatic load(input logic [7:0] v);
    ctl.shift_load_select <= 1'b0;
    par <= v;
    hold(6);
    ctl.clock_in <= 1'b1;
    hold(6);
    ctl.clock_in <= 1'b0;
    hold(6);
    ctl.shift_load_select <= 1'b1;
    hold(6);
    par <= ~v;
    hold(6);
  endtask
  task automatic shift(input logic use_blk, input logic s);
    ctl.serial_data_in <= s;
    hold(6);
    if (use_blk) ctl.clock_block_input <= 1'b1;
    else ctl.clock_in <= 1'b1;
    hold(6);
    ctl.clock_in <= 1'b0;
    ctl.clock_block_input <= 1'b0;
    hold(6);
  endtask
  // inhibit goes high only while the clock is high, so nothing shifts
  task automatic blocked(input logic [7:0] v);
    ctl.shift_load_select <= 1'b0;
    par <= v;
    ctl.clock_in <= 1'b1;
    hold(6);
    ctl.clock_block_input <= 1'b1;
    hold(6);
    ctl.shift_load_select <= 1'b1;
    hold(6);
    ctl.clock_in <= 1'b0;
    hold(6);
    ctl.clock_in <= 1'b1;
    hold(6);
    ctl.clock_block_input <= 1'b0;
    hold(6);
    ctl.clock_in <= 1'b0;
    hold(6);
  endtask
endmodule

// ===== tb/parallel_load_shift_register8_tb.sv
// self-checking bench for the parallel-load shift register
`timescale 1ns/1ns
module parallel_load_shift_register8_tb;
  logic ref_clk;
  logic rst;
  logic [7:0] par;
  shreg_pkg::pin_ctrl_t ctl;
  logic q_true;
  logic q_inv;
  int fail_count;
  int check_count;
  logic [7:0] q;

  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  shreg_ctrl_model u_ctrl (.ref_clk(ref_clk), .par(par), .ctl(ctl));
  parallel_load_shift_register8 u_parallel_load_shift_register8 (
    .ref_clk(ref_clk), .rst(rst), .parallel_data_in(par),
    .shift_load_select(ctl.shift_load_select), .clock_in(ctl.clock_in),
    .clock_block_input(ctl.clock_block_input), .serial_data_in(ctl.serial_data_in),
    .serial_out_true(q_true), .serial_out_inverted(q_inv)
  );

  task automatic check(input logic seen, input logic exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic check_out(input logic e);
    check(q_true, e);
    check(q_inv, ~e);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic test_reset();
    check_out(1'b0);
    $display("test reset done");
  endtask
  task automatic test_load_shift();
    q = 8'hA5;
    u_ctrl.load(q);
    check_out(q[7]);
    for (int i = 0; i < 12; i++) begin
      u_ctrl.shift(i[0], i[1]);
      q = {q[6:0], i[1]};
      check_out(q[7]);
    end
    $display("test load_shift done");
  endtask
  task automatic test_blocked();
    u_ctrl.blocked(8'h80);
    check_out(1'b1);
    $display("test blocked done");
  endtask
  task automatic test_mid_reset();
    u_ctrl.load(8'hFF);
    check_out(1'b1);
    rst <= 1'b1;
    u_ctrl.hold(3);
    check_out(1'b0);
    rst <= 1'b0;
    u_ctrl.hold(8);
    check_out(1'b0);
    u_ctrl.load(8'h81);
    check_out(1'b1);
    u_ctrl.shift(1'b0, 1'b0);
    check_out(1'b0);
    $display("test mid_reset done");
  endtask

  initial begin
    // nonblocking so the reset edge at time zero reaches the design's processes
    rst <= 1'b1;
    fail_count = 0;
    check_count = 0;
    repeat (10) @(posedge ref_clk);
    test_reset();
    rst <= 1'b0;
    u_ctrl.hold(4);
    test_load_shift();
    test_blocked();
    test_mid_reset();
    finish_test();
  end
endmodule
